// *** tc_map.svh ***
// Register offsets, field positions, reset values and rates for the timer
//------------------------------------------------------------------------
// What this block does
// R01: Sixteen-bit count in high and low bytes, counts up and wraps to zero.
// R02: Wrap from all ones sets overflow flag, held until software clears it.
// R03: Overflow interrupt raised only while overflow enable bit zero is set.
// R04: Source select zero counts clock divided by four; one counts edges.
// R05: Counts only while run enable is set; clear stops and holds count.
// R06: Compare unit reset input clears the count, except in asynchronous counter mode.
// R07: Oscillator enable forces both pins to inputs, ignoring direction.
// R08: Counter mode takes oscillator pin if oscillator enabled, else clock pin.
// R09: Sync bit ignored in timer mode; in counter mode zero means synchronise.
// R10: Synchronised counter mode synchronises after the prescaler stage; here both pins are synchronised ahead of the prescaler.
// R11: Sleep in synchronised counter mode stops count, prescaler keeps going.
// R12: After enabling counter mode, one falling edge needed before counting.
// R13: Asynchronous counter mode keeps counting in sleep and can interrupt.
// R14: Count not offered as capture or compare time base in async mode.
// R15: Byte reads return a valid value while the external clock runs.
// R16: Software should stop the counter before writing the count.
// R17: Software must allow for low byte wrap between two byte reads.
// R18: Prescale codes 11, 10, 01, 00 divide by 8, 4, 2, 1.
// R19: Control bits 7 and 6 read as zero and ignore writes.
// R20: Writing either count byte clears the prescaler.
// R21: Power-on reset clears control: stopped, divide by one.
// R22: Count write beats compare reset; compare reset never sets the flag.
//------------------------------------------------------------------------
`ifndef TC_MAP_SVH
`define TC_MAP_SVH

// Register offsets
`define TC_ADDR_FLAG   8'h0C
`define TC_ADDR_LOW    8'h0E
`define TC_ADDR_HIGH   8'h0F
`define TC_ADDR_CTRL   8'h10
`define TC_ADDR_IE     8'h8C

// Field positions and reset values
`define TC_FLAG_BIT    0
`define TC_IE_BIT      0
`define TC_CTRL_RESET  6'h00
`define TC_COUNT_MAX   16'hFFFF

// Timer mode rate: oscillator clock divided by four
`define TC_OSCILLATOR_CLOCK_DIV    4

`endif

// *** tc_pkg.sv ***
// Types shared by the sixteen-bit timer and its helpers
package tc_pkg;

    // Control register fields, bit 5 down to bit 0
    typedef struct packed {
        logic [1:0] prescale_select;     // hi, lo
        logic       oscillator_enable;
        logic       external_sync_bypass_n;
        logic       clock_source_select;
        logic       run_enable;
    } tc_ctrl_t;

    // Register port request from the processor
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tc_bus_t;

    // Counter-mode arming after enable
    typedef enum logic [1:0] {
        TC_ARM_OFF  = 2'b00,
        TC_ARM_WAIT = 2'b01,
        TC_ARM_LIVE = 2'b10
    } tc_arm_t;

    // Divide mask for a prescale code: ratio minus one
    function automatic logic [2:0] tc_ps_mask(input logic [1:0] sel);
        case (sel)
            2'h0:    tc_ps_mask = 3'h0;
            2'h1:    tc_ps_mask = 3'h1;
            2'h2:    tc_ps_mask = 3'h3;
            default: tc_ps_mask = 3'h7;
        endcase
    endfunction

endpackage

// *** tc_sync2.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module tc_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk,       // System clock
    input  wire logic         srst,      // Synchronous reset
    input  wire logic [W-1:0] async_in,  // Pin levels
    output logic      [W-1:0] sync_out   // Levels on clk
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tc_sync_st_t;

    tc_sync_st_t st;
    tc_sync_st_t next_st;

    // First stage feeds only the second
    always_comb begin
        next_st    = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;
endmodule

// *** tc_prescale.sv ***
// Two-bit selectable prescaler, divide by 1, 2, 4 or 8
`timescale 1ns/1ps
module tc_prescale (
    input  wire logic       clk,    // System clock
    input  wire logic       srst,   // Synchronous reset
    input  wire logic       clear,  // Count byte written
    input  wire logic       tick,   // Selected source edge
    input  wire logic [1:0] sel,    // Prescale code
    output logic            pulse   // Divided tick
);
    import tc_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
    } tc_pre_st_t;

    tc_pre_st_t st;
    tc_pre_st_t next_st;
    logic [2:0] mask;

    // Free-running like a ripple chain; taps picked by the code // R10
    assign mask  = tc_ps_mask(sel);
    assign pulse = tick && !clear && ((st.cnt & mask) == mask); // R18

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.cnt = 3'h0; // R20
        end else if (tick) begin
            next_st.cnt = st.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // A count write restarts the divide chain
    AST_PRE_CLEAR: assert property (@(posedge clk) disable iff (srst) // R20
        clear |=> st.cnt == 3'h0)
        else $error("prescaler not cleared by count write");
endmodule

// *** tc_timer16.sv ***
// Sixteen-bit timer/counter with prescaler, overflow flag and register port
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "tc_map.svh"
module tc_timer16 (
    input  wire logic        clk,           // System clock, 50 MHz
    input  wire logic        srst,          // Power-on reset
    input  tc_pkg::tc_bus_t  bus,           // Register request
    output logic [7:0]       rdata,         // Read data, next cycle
    input  wire logic        cmp_reset,     // Compare unit trigger
    input  wire logic        sleep,         // Processor asleep
    input  wire logic        osc_in_pin,    // Oscillator input pin
    input  wire logic        ext_clk_pin,   // External clock pin
    input  wire logic [1:0]  port_dir,      // Direction bits, 1 = input
    output logic             irq,           // Overflow interrupt
    output logic [1:0]       pin_oe,        // Port pin output enables
    output logic             time_base_ok   // Usable by capture/compare
);
    import tc_pkg::*;

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        tc_ctrl_t    ctrl;
        logic        flag;
        logic        ie;
        tc_arm_t     arm;
        logic [1:0]  fdiv;
        logic        ext_prev;
        logic [7:0]  rdata;
        logic        irq;
        logic [1:0]  pin_oe;
        logic        tb_ok;
    } tc_state_t;

    tc_state_t st;
    tc_state_t next_st;

    //--------------------------------------------------------------------
    // Decode helpers
    //--------------------------------------------------------------------
    function automatic logic tc_hit(input tc_bus_t b, input logic [7:0] a);
        tc_hit = (b.addr == a);
    endfunction

    logic       wr_low;
    logic       wr_high;
    logic       wr_count;
    logic       wr_ctrl;
    logic       wr_flag;
    logic       wr_ie;
    logic [1:0] pins_sync;
    logic       ext_now;
    logic       ext_rise;
    logic       ext_fall;
    logic       counter_mode;
    logic       async_mode;
    logic       oscillator_clock_tick;
    logic       pre_tick;
    logic       pre_pulse;
    logic       inc;
    logic       wrap;
    logic       cmp_take;

    assign wr_low   = bus.wr && tc_hit(bus, `TC_ADDR_LOW);
    assign wr_high  = bus.wr && tc_hit(bus, `TC_ADDR_HIGH);
    assign wr_count = wr_low || wr_high;
    assign wr_ctrl  = bus.wr && tc_hit(bus, `TC_ADDR_CTRL);
    assign wr_flag  = bus.wr && tc_hit(bus, `TC_ADDR_FLAG);
    assign wr_ie    = bus.wr && tc_hit(bus, `TC_ADDR_IE);

    //--------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------
    // Both pins pass two flops; reads and edges see only the settled
    // value, so a byte read never catches a half-updated count
    tc_sync2 #(
        .W (2)
    ) tc_sync2_inst (
        .clk      (clk),
        .srst     (srst),
        .async_in ({osc_in_pin, ext_clk_pin}),
        .sync_out (pins_sync)
    ); // R15

    //--------------------------------------------------------------------
    // Clock source selection
    //--------------------------------------------------------------------
    // Sync bit only matters once the external source is selected
    assign counter_mode = st.ctrl.clock_source_select; // R04
    assign async_mode   = counter_mode &&
                          st.ctrl.external_sync_bypass_n; // R09

    // External source: oscillator pin when enabled, else clock pin
    assign ext_now  = st.ctrl.oscillator_enable ? pins_sync[1]
                                                : pins_sync[0]; // R08
    assign ext_rise = ext_now && !st.ext_prev;
    assign ext_fall = !ext_now && st.ext_prev;

    // Instruction-cycle enable: one pulse in four system clocks
    assign oscillator_clock_tick = (st.fdiv == 2'(`TC_OSCILLATOR_CLOCK_DIV - 1)); // R04

    //--------------------------------------------------------------------
    // Prescaler input
    //--------------------------------------------------------------------
    // Counter mode only ticks once armed by a falling edge, so a pin
    // already high at enable does not give a phantom first count.
    // The ripple prescaler is modelled as a counter stepped by edge
    // enables; it sits ahead of the count, as the synchronised path
    // expects, and no extra clock domain is created
    assign pre_tick = st.ctrl.run_enable &&
                      (counter_mode ? (ext_rise &&
                                       st.arm == TC_ARM_LIVE)
                                    : oscillator_clock_tick); // R05 R12

    tc_prescale tc_prescale_inst (
        .clk   (clk),
        .srst  (srst),
        .clear (wr_count),
        .tick  (pre_tick),
        .sel   (st.ctrl.prescale_select),
        .pulse (pre_pulse)
    ); // R18 R20

    //--------------------------------------------------------------------
    // Count enable
    //--------------------------------------------------------------------
    // Sleep gates the increment outside async mode, so only the async path keeps
    // counting; the prescaler still sees every edge meanwhile
    assign inc = pre_pulse && (!sleep || async_mode); // R11 R13

    // Compare trigger is unreliable against an async count, and a
    // count write always beats it
    assign cmp_take = cmp_reset && !async_mode && !wr_count; // R06 R22

    // Wrap only by counting, never by a write or a compare clear
    assign wrap = inc && !cmp_take && !wr_count &&
                  (st.count == `TC_COUNT_MAX); // R01 R02 R22

    //--------------------------------------------------------------------
    // Read multiplexer
    //--------------------------------------------------------------------
    // Unmapped offsets read zero; upper control bits are not stored.
    // Reading the settled copy keeps each byte valid mid-count
    function automatic logic [7:0] tc_read(input logic [7:0] a,
                                           input tc_state_t s);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `TC_ADDR_LOW:  d = s.count[7:0];
            `TC_ADDR_HIGH: d = s.count[15:8];
            `TC_ADDR_CTRL: d = {2'h0, s.ctrl}; // R19
            `TC_ADDR_FLAG: d = {7'h00, s.flag};
            `TC_ADDR_IE:   d = {7'h00, s.ie};
            default:       d = 8'h00;
        endcase
        tc_read = d;
    endfunction

    //--------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Instruction-cycle divider runs free from reset
        next_st.fdiv     = st.fdiv + 2'h1;
        next_st.ext_prev = ext_now;

        // Control register; bits 7 and 6 are dropped
        if (wr_ctrl) begin
            next_st.ctrl = tc_ctrl_t'(bus.wdata[5:0]); // R19
        end
        if (wr_ie) begin
            next_st.ie = bus.wdata[`TC_IE_BIT]; // R03
        end

        // Arming: a fresh enable in counter mode waits for a fall
        if (!next_st.ctrl.run_enable ||
            !next_st.ctrl.clock_source_select) begin
            next_st.arm = TC_ARM_OFF;
        end else begin
            case (st.arm)
                TC_ARM_OFF: begin
                    next_st.arm = TC_ARM_WAIT;
                end
                TC_ARM_WAIT: begin
                    if (ext_fall) begin
                        next_st.arm = TC_ARM_LIVE; // R12
                    end
                end
                TC_ARM_LIVE: begin
                    next_st.arm = TC_ARM_LIVE;
                end
                default: begin
                    next_st.arm = TC_ARM_OFF;
                end
            endcase
        end

        // Count: byte writes beat the compare clear, which beats counting.
        // A write that lands on an increment loses the increment; software
        // should stop the counter first, and pair two byte reads with care
        // since the low byte can wrap into the high byte between them
        if (wr_count) begin
            if (wr_low) begin
                next_st.count[7:0] = bus.wdata;
            end
            if (wr_high) begin
                next_st.count[15:8] = bus.wdata;
            end
        end else if (cmp_take) begin
            next_st.count = 16'h0000; // R06
        end else if (inc) begin
            next_st.count = st.count + 16'h0001; // R01 R05
        end

        // Hardware set wins over a software clear in the same cycle
        if (wr_flag) begin
            next_st.flag = bus.wdata[`TC_FLAG_BIT];
        end
        if (wrap) begin
            next_st.flag = 1'b1; // R02
        end

        // Read data stands only in the cycle after the strobe
        next_st.rdata = bus.rd ? tc_read(bus.addr, st) : 8'h00; // R15

        // Output flops follow the new state so they never lag it
        next_st.irq    = next_st.flag && next_st.ie; // R03 R13
        next_st.pin_oe = next_st.ctrl.oscillator_enable ? 2'h0
                                                         : ~port_dir; // R07
        next_st.tb_ok  = !(next_st.ctrl.clock_source_select &&
                           next_st.ctrl.external_sync_bypass_n); // R14
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    // Only power-on reset reaches here; apart from the compare reset
    // clearing the count, no other reset touches the count or the control register
    always_ff @(posedge clk) begin
        if (srst) begin
            st      <= '0;
            st.ctrl <= tc_ctrl_t'(`TC_CTRL_RESET); // R21
        end else begin
            st <= next_st;
        end
    end

    // Every output comes straight from a flop
    assign rdata        = st.rdata;
    assign irq          = st.irq;
    assign pin_oe       = st.pin_oe;
    assign time_base_ok = st.tb_ok;

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    // A counted wrap always leaves the flag set
    AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (srst) // R02
        wrap |=> st.flag)
        else $error("overflow flag not set after wrap");

    // Flag holds until software writes it
    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (srst) // R02
        st.flag && !wr_flag |=> st.flag)
        else $error("overflow flag dropped on its own");

    // Interrupt is exactly flag masked by the enable
    AST_IRQ_MASK: assert property (@(posedge clk) disable iff (srst) // R03
        irq == (st.flag && st.ie))
        else $error("interrupt does not follow flag and enable");

    // Timer mode steps only on the instruction-cycle enable
    AST_TIMER_RATE: assert property (@(posedge clk) disable iff (srst) // R04
        !counter_mode && !oscillator_clock_tick |-> !pre_tick)
        else $error("timer ticked off the instruction cycle");

    // Stopped and untouched, the count holds
    AST_STOP_HOLD: assert property (@(posedge clk) disable iff (srst) // R05
        !st.ctrl.run_enable && !wr_count && !cmp_take
        |=> st.count == $past(st.count))
        else $error("count moved while stopped");

    // Compare trigger clears the count outside async mode
    AST_CMP_CLEAR: assert property (@(posedge clk) disable iff (srst) // R06
        cmp_take |=> st.count == 16'h0000)
        else $error("compare trigger did not clear count");

    // Oscillator enable takes both pins away from the port drivers
    AST_OSC_INPUTS: assert property (@(posedge clk) disable iff (srst) // R07
        st.ctrl.oscillator_enable |-> pin_oe == 2'h0)
        else $error("oscillator pins still driven");

    // Oscillator enable picks the oscillator input pin
    AST_SRC_PIN: assert property (@(posedge clk) disable iff (srst) // R08
        st.ctrl.oscillator_enable
        |-> ext_now == pins_sync[1])
        else $error("wrong external source pin");

    // Timer mode is never asynchronous, whatever the sync bit says
    AST_SYNC_IGNORED: assert property (@(posedge clk) disable iff (srst) // R09
        !counter_mode
        |-> !async_mode)
        else $error("sync bit acted in timer mode");

    // No increment until the arming fall has been seen
    AST_ARM_FALL: assert property (@(posedge clk) disable iff (srst) // R12
        counter_mode && st.arm != TC_ARM_LIVE |-> !pre_tick)
        else $error("counter ticked before a falling edge");

    // Asleep in synchronised counter mode the count stands still
    AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (srst) // R11
        sleep && counter_mode && !async_mode && !wr_count && !cmp_take
        |=> st.count == $past(st.count))
        else $error("count moved in sleep without async mode");

    // Async mode keeps counting through sleep
    AST_ASYNC_SLEEP: assert property (@(posedge clk) disable iff (srst) // R13
        async_mode && sleep && pre_pulse |-> inc)
        else $error("async count stopped in sleep");

    // Async mode never offers the count as a time base
    AST_ASYNC_BASE: assert property (@(posedge clk) disable iff (srst) // R14
        async_mode |-> !time_base_ok)
        else $error("async count offered as time base");

    // Read data is zero outside the cycle after a read strobe
    AST_READ_ONE: assert property (@(posedge clk) disable iff (srst) // R15
        !$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");

    // Upper control bits always read as zero
    AST_CTRL_TOP: assert property (@(posedge clk) disable iff (srst) // R19
        bus.rd && bus.addr == `TC_ADDR_CTRL
        |=> rdata[7:6] == 2'h0)
        else $error("upper control bits read as one");

    // A count write beats a coincident compare trigger
    AST_WRITE_WINS: assert property (@(posedge clk) disable iff (srst) // R22
        wr_low && cmp_reset && !async_mode
        |=> st.count[7:0] == $past(bus.wdata))
        else $error("compare trigger beat a count write");
endmodule

// *** tc_ext_src.sv ***
// Model of the external clock source feeding the timer pins
`timescale 1ns/1ps
module tc_ext_src (
    input  wire logic go,      // Burst start
    input  wire logic use_osc, // Crystal pin, else clock pin
    output logic      osc_pin, // Oscillator input pin
    output logic      clk_pin  // External clock pin
);
    logic lvl = 1'b0;
    // Five slow pulses per burst; idle low, so arming needs a fall
    always @(posedge go) begin
        repeat (5) begin
            #160 lvl = 1'b1;
            #160 lvl = 1'b0;
        end
    end
    // Idle pin stays low, so a swapped source counts nothing
    assign osc_pin = use_osc & lvl;
    assign clk_pin = ~use_osc & lvl;
endmodule

// *** tc_timer16_tb.sv ***
// Self-checking testbench for the sixteen-bit timer
`timescale 1ns/1ps
`include "tc_map.svh"
module tc_timer16_tb;
    import tc_pkg::*;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    tc_bus_t    bus = '0;
    logic [7:0] rdata;
    logic       cmp_reset = 1'b0;
    logic       sleep = 1'b0;
    logic       osc_pin;
    logic       clk_pin;
    logic [1:0] port_dir = 2'h0;
    logic       irq;
    logic [1:0] pin_oe;
    logic       tb_ok;
    logic       go = 1'b0;
    logic       use_osc = 1'b0;
    logic [7:0] v;
    logic [7:0] w;
    int         fails = 0;
    int         n_checks = 0;

    always #10 clk = ~clk;

    tc_timer16 tc_timer16_inst (.clk(clk), .srst(srst), .bus(bus),
        .rdata(rdata), .cmp_reset(cmp_reset), .sleep(sleep),
        .osc_in_pin(osc_pin), .ext_clk_pin(clk_pin), .port_dir(port_dir),
        .irq(irq), .pin_oe(pin_oe), .time_base_ok(tb_ok));
    tc_ext_src tc_ext_src_inst (.go(go), .use_osc(use_osc),
        .osc_pin(osc_pin), .clk_pin(clk_pin));

    //----------------------------------------------------------------
    // Register port tasks and comparison
    //----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Tolerance covers start and stop latency of rate runs
    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g, input int tol);
        n_checks++;
        if ($isunknown(g) || (g > e + tol) || (g + tol < e)) begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    //----------------------------------------------------------------
    // Test sequence
    //----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(`TC_ADDR_CTRL, v);
        chk("ctrl reset", 8'h00, v, 0);
        wr(`TC_ADDR_CTRL, 8'hFE);
        rd(`TC_ADDR_CTRL, v);
        chk("ctrl", 8'h3E, v, 0);
        chk("oe osc on", 8'h00, {6'h0, pin_oe}, 0);
        wr(`TC_ADDR_CTRL, 8'h00);
        rd(`TC_ADDR_CTRL, v);
        chk("oe osc off", 8'h03, {6'h0, pin_oe}, 0);
        for (int c = 0; c < 4; c++) begin
            wr(`TC_ADDR_LOW, 8'h00);
            wr(`TC_ADDR_HIGH, 8'h00);
            wr(`TC_ADDR_CTRL, {2'h0, c[1:0], 4'h1});
            repeat (254) @(posedge clk);
            wr(`TC_ADDR_CTRL, 8'h00);
            rd(`TC_ADDR_LOW, v);
            chk("rate", 8'(64 >> c), v, 2);
        end
        repeat (40) @(posedge clk);
        rd(`TC_ADDR_LOW, w);
        chk("held", v, w, 0);
        wr(`TC_ADDR_LOW, 8'hF0);
        wr(`TC_ADDR_HIGH, 8'hFF);
        wr(`TC_ADDR_CTRL, 8'h01);
        repeat (200) @(posedge clk);
        wr(`TC_ADDR_CTRL, 8'h00);
        rd(`TC_ADDR_FLAG, v);
        chk("flag", 8'h01, v & 8'h01, 0);
        chk("irq masked", 8'h00, {7'h0, irq}, 0);
        wr(`TC_ADDR_IE, 8'h01);
        rd(`TC_ADDR_HIGH, v);
        chk("high wrap", 8'h00, v, 0);
        chk("irq", 8'h01, {7'h0, irq}, 0);
        wr(`TC_ADDR_FLAG, 8'h00);
        rd(`TC_ADDR_FLAG, v);
        chk("irq clr", 8'h00, {7'h0, irq}, 0);
        // Source pin, sync and sleep in every combination
        for (int i = 0; i < 8; i++) begin
            wr(`TC_ADDR_LOW, 8'h00);
            wr(`TC_ADDR_HIGH, 8'h00);
            use_osc <= i[0];
            wr(`TC_ADDR_CTRL, {4'h0, i[0], i[1], 2'h3});
            sleep <= i[2];
            go <= 1'b1;
            repeat (120) @(posedge clk);
            go <= 1'b0;
            chk("time base", {7'h0, ~i[1]}, {7'h0, tb_ok}, 0);
            sleep <= 1'b0;
            wr(`TC_ADDR_CTRL, 8'h00);
            rd(`TC_ADDR_LOW, v);
            w = (i[2] && !i[1]) ? 8'h00 : 8'h04;
            chk("edges", w, v, 0);
        end
        wr(`TC_ADDR_HIGH, 8'h12);
        @(posedge clk) cmp_reset <= 1'b1;
        @(posedge clk) cmp_reset <= 1'b0;
        rd(`TC_ADDR_HIGH, v);
        chk("cmp clear", 8'h00, v, 0);
        wr(`TC_ADDR_HIGH, 8'h12);
        @(posedge clk) bus <= '{`TC_ADDR_LOW, 8'h55, 1'b1, 1'b0};
        cmp_reset <= 1'b1;
        @(posedge clk) bus.wr <= 1'b0;
        cmp_reset <= 1'b0;
        rd(`TC_ADDR_HIGH, v);
        chk("write wins", 8'h12, v, 0);
        rd(`TC_ADDR_FLAG, v);
        chk("no flag", 8'h00, v & 8'h01, 0);
        summarize();
    end

    // Watchdog far beyond the expected run length
    initial begin
        #1000000;
        fails++;
        summarize();
    end
endmodule
